// >>> sds_params.svh
// constants of the stepper drive sequencer: offsets, fields, resets, timing
`ifndef SDS_PARAMS_SVH
`define SDS_PARAMS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define SDS_CLK_NS          25
`define SDS_OFF_MAX_NS      12600
`define SDS_OFF_STEP_NS     1600
`define SDS_OFF_MIN_NS      1400
`define SDS_REST_IDLE_US    100

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SDS_ADDR_STATUS     8'h00
`define SDS_ADDR_MASK       8'h04
`define SDS_ADDR_STATE      8'h08
`define SDS_ADDR_CONFIG     8'h0C

// ----------------------------------------------------------------------
// event bits of status and mask
// ----------------------------------------------------------------------
`define SDS_EV_FAULT        0
`define SDS_EV_REST         1
`define SDS_EV_STEP         2
`define SDS_EV_CLEAR        3
`define SDS_EV_W            4

// ----------------------------------------------------------------------
// state register fields
// ----------------------------------------------------------------------
`define SDS_STATE_POS_LSB   0
`define SDS_STATE_ST_LSB    8
`define SDS_STATE_LVL_LSB   10
`define SDS_STATE_FLT_LSB   12

// ----------------------------------------------------------------------
// reset values and sequence lengths
// ----------------------------------------------------------------------
`define SDS_MASK_RST        4'h0
`define SDS_STATUS_RST      4'h0
`define SDS_SEQ_LEN_TWO     5'h08
`define SDS_SEQ_LEN_FIVE    5'h14

`endif

// >>> sds_pkg.sv
// types shared by the stepper drive sequencer
package sds_pkg;

  // current level selected for the phase bridges
  typedef enum logic [1:0] {
    SDS_LVL_ZERO  = 2'h0,
    SDS_LVL_REST  = 2'h1,
    SDS_LVL_SLEW  = 2'h2,
    SDS_LVL_BOOST = 2'h3
  } sds_level_t;

  // drive state, gray along off -> rest -> run
  typedef enum logic [1:0] {
    SDS_ST_OFF   = 2'h0,
    SDS_ST_REST  = 2'h1,
    SDS_ST_RUN   = 2'h3,
    SDS_ST_FAULT = 2'h2
  } sds_state_t;

  // main state register of the top module, apart from reset release and submodules
  typedef struct packed {
    sds_state_t  state;
    sds_level_t  level;
    logic [4:0]  pos;
    logic [23:0] idle_cnt;
    logic        step_d;
    logic        fault_d;
    logic [4:0]  phase_pos;
    logic [4:0]  phase_neg;
    logic        bridge_en;
    logic        fast_decay;
    logic        fault_n;
    logic        fault_led;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic        irq;
    logic [31:0] rdata;
  } sds_top_state_t;

endpackage : sds_pkg

// >>> sds_sync.sv
// two-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
`default_nettype none
module sds_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sds_sync_state_t;

  sds_sync_state_t s;
  sds_sync_state_t next_s;

  // meta is read only by sync
  always_comb begin
    next_s.meta = d;
    next_s.sync = s.meta;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.sync;
endmodule : sds_sync
`default_nettype wire

// >>> sds_offtime.sv
// chopper off-time timer, length chosen by a three-bit code
`timescale 1ns/1ps
`default_nettype none
`include "sds_params.svh"
module sds_offtime #(
  parameter int CNT_W = 10
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       trip,
  input  wire logic [2:0] code,
  output logic            off_active
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             act;
  } sds_off_state_t;

  sds_off_state_t s;
  sds_off_state_t next_s;

  // code 0 longest, each step shorter by a fixed time
  function automatic logic [CNT_W-1:0] off_cycles(input logic [2:0] c);
    int ns;
    ns = `SDS_OFF_MAX_NS - int'(c) * `SDS_OFF_STEP_NS;
    return CNT_W'(ns / `SDS_CLK_NS);
  endfunction

  // start on a trip, hold off until the count runs out
  always_comb begin
    next_s = s;
    if (!run) begin
      next_s = '0;
    end else if (s.act) begin
      if (s.cnt == CNT_W'(1)) begin
        next_s.act = 1'b0;
        next_s.cnt = '0;
      end else begin
        next_s.cnt = s.cnt - CNT_W'(1);
      end
    end else if (trip) begin
      next_s.act = 1'b1;
      next_s.cnt = off_cycles(code);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign off_active = s.act;
endmodule : sds_offtime
`default_nettype wire

// >>> sds_top.sv
// stepper drive sequencer: step sequence, current level, chopper, faults
// Notes on behaviour
// - rest inhibit on keeps normal current at rest; off drops to rest level
// - slew level applies by itself while running without a ramp request
// - ramp request boosts with gate on, zero with gate off, else normal
// - fast decay selector on picks four-quadrant, off two-quadrant decay
// - three-bit code sets off-time, longest at zero, bit0 least significant
// - host gives only step clock; sequence built inside, half or full step
// - phase-count selector on gives five-phase, off gives two-phase sequence
// - one step per active edge: rising with polarity on, falling otherwise
// - direction is xor of direction input and its polarity selector
// - motor driven only while enable input held low
// - overtemperature disables the bridges and asserts the fault output
// - fault output active on undervoltage, overvoltage, overtemp or overload
// - fault output is active low, high when no fault
// - supply or overload fault also disables drive and lights indicator
`timescale 1ns/1ps
`default_nettype none
`include "sds_params.svh"
module sds_top
  import sds_pkg::*;
#(
  parameter int REST_IDLE_CYCLES = (`SDS_REST_IDLE_US * 1000) / `SDS_CLK_NS,
  parameter int OFF_CNT_W        = 10
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  // host inputs
  input  wire logic        step_clk,
  input  wire logic        dir_in,
  input  wire logic        enable_n,
  input  wire logic        ramp_req,
  // selectors
  input  wire logic        edge_polarity_select,
  input  wire logic        dir_polarity_select,
  input  wire logic        half_step_select,
  input  wire logic        rest_reduction_inhibit,
  input  wire logic        five_phase_select,
  input  wire logic        ramp_current_gate,
  input  wire logic        fast_decay_select,
  input  wire logic        off_time_bit0,
  input  wire logic        off_time_bit1,
  input  wire logic        off_time_bit2,
  // analog monitors
  input  wire logic        chop_trip,
  input  wire logic        flt_undervolt,
  input  wire logic        flt_overvolt,
  input  wire logic        flt_overtemp,
  input  wire logic        flt_overload,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // drive outputs
  output logic      [4:0]  phase_pos,
  output logic      [4:0]  phase_neg,
  output logic             bridge_en,
  output logic      [1:0]  current_level,
  output logic             fast_decay,
  output logic             chop_off,
  output logic             fault_n,
  output logic             fault_led,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  // asynchronous assert, two-flop release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] sy;

  logic       sy_step;
  logic       sy_dir;
  logic       sy_en_n;
  logic       sy_ramp;

  // enable inverted: sync reset reads as disabled
  sds_sync #(
    .WIDTH (4)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({ramp_req, ~enable_n, dir_in, step_clk}),
    .q     (sy)
  );

  assign sy_step = sy[0];
  assign sy_dir  = sy[1];
  assign sy_en_n = ~sy[2];
  assign sy_ramp = sy[3];

  // ----------------------------------------------------------------------
  // sequence helpers
  // ----------------------------------------------------------------------
  // next index; full step keeps to odd indexes (two windings on in two-phase, all five in five-phase)
  function automatic logic [4:0] step_pos(input logic [4:0] pos, input logic up,
                                          input logic half, input logic [4:0] len);
    logic [4:0] p;
    logic [4:0] b;

    p = (pos >= len) ? 5'h00 : pos;
    b = p | 5'h01;

    if (half) begin
      if (up) begin
        step_pos = (p == len - 5'h01) ? 5'h00 : p + 5'h01;
      end else begin
        step_pos = (p == 5'h00) ? len - 5'h01 : p - 5'h01;
      end
    end else if (up) begin
      step_pos = (b + 5'h02 >= len) ? b + 5'h02 - len : b + 5'h02;
    end else begin
      step_pos = (b < 5'h02) ? b + len - 5'h02 : b - 5'h02;
    end
  endfunction

  // winding polarity for an index: {positive, negative}
  function automatic logic [9:0] phase_map(input logic [4:0] pos, input logic five);
    int t;
    logic [4:0] pp;
    logic [4:0] pn;

    pp = 5'h00;
    pn = 5'h00;

    for (int k = 0; k < 5; k++) begin
      if (five) begin
        t = (int'(pos) + 20 - 4 * k) % 20;
        pp[k] = (t >= 1) && (t <= 9);
        pn[k] = (t >= 11);
      end else if (k == 0 || k == 2) begin
        t = (int'(pos) + 8 - k) % 8;
        pp[k] = (t >= 1) && (t <= 3);
        pn[k] = (t >= 5);
      end
    end
    phase_map = {pp, pn};
  endfunction

  // ----------------------------------------------------------------------
  // main state
  // ----------------------------------------------------------------------
  sds_top_state_t s;
  sds_top_state_t next_s;

  logic           act_edge;
  logic           dir_up;
  logic           fault_any;
  logic           supply_bad;

  logic [4:0]     seq_len;
  logic [3:0]     ev;
  logic [3:0]     w1c;
  logic [9:0]     pmap;
  logic           driving;

  // edge, direction and fault terms
  always_comb begin
    act_edge   = edge_polarity_select ? (sy_step & ~s.step_d)
                                      : (~sy_step & s.step_d);
    dir_up     = sy_dir ^ dir_polarity_select; // cw counts up
    supply_bad = flt_undervolt | flt_overvolt | flt_overload;
    fault_any  = supply_bad | flt_overtemp;
    seq_len    = five_phase_select ? `SDS_SEQ_LEN_FIVE
                                   : `SDS_SEQ_LEN_TWO;
  end

  // state machine, sequencing, current level, registers
  always_comb begin
    next_s         = s;
    ev             = 4'h0;
    w1c            = 4'h0;
    next_s.step_d  = sy_step;
    next_s.fault_d = fault_any;
    next_s.rdata   = 32'h0000_0000;

    unique case (s.state)
      SDS_ST_OFF: begin
        if (fault_any) begin
          next_s.state = SDS_ST_FAULT;
        end else if (!sy_en_n) begin
          next_s.state    = SDS_ST_REST;
          next_s.idle_cnt = 24'h00_0000;
        end
      end

      SDS_ST_REST, SDS_ST_RUN: begin
        if (fault_any) begin
          next_s.state = SDS_ST_FAULT;
        end else if (sy_en_n) begin
          next_s.state = SDS_ST_OFF;
        end else if (act_edge) begin
          next_s.state    = SDS_ST_RUN;
          next_s.idle_cnt = 24'h00_0000;
          next_s.pos      = step_pos(s.pos, dir_up, half_step_select, seq_len);
          ev[`SDS_EV_STEP] = 1'b1;
        end else if (s.state == SDS_ST_RUN) begin
          if (s.idle_cnt >= 24'(REST_IDLE_CYCLES - 1)) begin
            next_s.state    = SDS_ST_REST;
            ev[`SDS_EV_REST] = 1'b1;
          end else begin
            next_s.idle_cnt = s.idle_cnt + 24'h00_0001;
          end
        end
      end

      // held until every fault input clears
      SDS_ST_FAULT: begin
        if (!fault_any) begin
          next_s.state = SDS_ST_OFF;
        end
      end
    endcase

    // bridges follow the next state
    driving          = (next_s.state == SDS_ST_REST) || (next_s.state == SDS_ST_RUN);
    pmap             = phase_map(next_s.pos, five_phase_select);
    next_s.bridge_en = driving;
    next_s.phase_pos = driving ? pmap[9:5] : 5'h00;
    next_s.phase_neg = driving ? pmap[4:0] : 5'h00;

    // current level choice
    if (!driving) begin
      next_s.level = SDS_LVL_ZERO;
    end else if (sy_ramp) begin
      next_s.level = ramp_current_gate ? SDS_LVL_BOOST : SDS_LVL_ZERO;
    end else if (next_s.state == SDS_ST_RUN) begin
      next_s.level = SDS_LVL_SLEW;
    end else begin
      next_s.level = rest_reduction_inhibit ? SDS_LVL_SLEW : SDS_LVL_REST;
    end

    // chopper decay and fault pins
    next_s.fast_decay = fast_decay_select;
    next_s.fault_n    = ~fault_any;
    next_s.fault_led  = supply_bad;

    // events
    ev[`SDS_EV_FAULT] = fault_any & ~s.fault_d;
    ev[`SDS_EV_CLEAR] = ~fault_any & s.fault_d;

    // register writes; a new event wins over its clear
    if (reg_wr) begin
      if (reg_addr == `SDS_ADDR_STATUS) begin
        w1c = reg_wdata[3:0];
      end
      if (reg_addr == `SDS_ADDR_MASK) begin
        next_s.mask = reg_wdata[3:0];
      end
    end
    next_s.status = (s.status & ~w1c) | ev;
    next_s.irq    = |(next_s.status & next_s.mask);

    // register reads, answered next cycle
    if (reg_rd) begin
      unique case (reg_addr)
        `SDS_ADDR_STATUS: next_s.rdata[3:0] = s.status;
        `SDS_ADDR_MASK:   next_s.rdata[3:0] = s.mask;

        `SDS_ADDR_STATE: begin
          next_s.rdata[`SDS_STATE_POS_LSB +: 5] = s.pos;
          next_s.rdata[`SDS_STATE_ST_LSB +: 2]  = s.state;
          next_s.rdata[`SDS_STATE_LVL_LSB +: 2] = s.level;
          next_s.rdata[`SDS_STATE_FLT_LSB +: 4] = {flt_overload, flt_overtemp,
                                                   flt_overvolt, flt_undervolt};
        end

        `SDS_ADDR_CONFIG: begin
          next_s.rdata[10:0] = {off_time_bit2, off_time_bit1, off_time_bit0,
                                fast_decay_select, ramp_current_gate,
                                five_phase_select, rest_reduction_inhibit,
                                half_step_select, dir_polarity_select,
                                edge_polarity_select, sy_en_n};
        end

        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s         <= '0;
      s.fault_n <= 1'b1;
      s.mask    <= `SDS_MASK_RST;
      s.status  <= `SDS_STATUS_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // chopper off-time
  // ----------------------------------------------------------------------
  sds_offtime #(
    .CNT_W (OFF_CNT_W)
  ) u_offtime (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .run        (s.bridge_en),
    .trip       (chop_trip),
    .code       ({off_time_bit2, off_time_bit1, off_time_bit0}),
    .off_active (chop_off)
  );

  // outputs straight from the state register
  assign reg_rdata     = s.rdata;

  assign phase_pos     = s.phase_pos;
  assign phase_neg     = s.phase_neg;
  assign bridge_en     = s.bridge_en;
  assign current_level = s.level;

  assign fast_decay    = s.fast_decay;
  assign fault_n       = s.fault_n;
  assign fault_led     = s.fault_led;
  assign irq           = s.irq;

endmodule : sds_top
`default_nettype wire

// >>> sds_top_props.sv
// port-level assertion checker for the stepper drive sequencer
`timescale 1ns/1ps
`default_nettype none
module sds_top_props
  import sds_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       enable_n,
  input wire logic       ramp_current_gate,
  input wire logic       rest_reduction_inhibit,
  input wire logic       fast_decay_select,
  input wire logic       off_time_bit0,
  input wire logic       off_time_bit1,
  input wire logic       off_time_bit2,
  input wire logic       chop_trip,
  input wire logic       flt_undervolt,
  input wire logic       flt_overvolt,
  input wire logic       flt_overtemp,
  input wire logic       flt_overload,
  input wire logic [4:0] phase_pos,
  input wire logic [4:0] phase_neg,
  input wire logic       bridge_en,
  input wire logic [1:0] current_level,
  input wire logic       fast_decay,
  input wire logic       chop_off,
  input wire logic       fault_n,
  input wire logic       fault_led
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------------
  logic       any_flt;
  logic       sup_flt;
  logic [9:0] off_len;
  logic [9:0] run_len;
  // fault groups and expected off-time length
  assign any_flt = flt_undervolt | flt_overvolt | flt_overtemp | flt_overload;
  assign sup_flt = flt_undervolt | flt_overvolt | flt_overload;
  assign off_len = 10'h1F8 - 10'h040 * {7'h00, off_time_bit2, off_time_bit1, off_time_bit0};
  // length of the current off-time run
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      run_len <= 10'h000;
    end else begin
      run_len <= chop_off ? run_len + 10'h001 : 10'h000;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_flt_on; any_flt |=> !fault_n; endproperty
  a_flt_on: assert property (p_flt_on) else $error("fault output not low");
  property p_flt_off; !any_flt |=> fault_n; endproperty
  a_flt_off: assert property (p_flt_off) else $error("fault output not released");
  property p_flt_drv; any_flt |=> !bridge_en && phase_pos == 5'h00 && phase_neg == 5'h00; endproperty
  a_flt_drv: assert property (p_flt_drv) else $error("drive on during fault");
  property p_led; sup_flt |=> fault_led; endproperty
  a_led: assert property (p_led) else $error("indicator off on supply fault");
  property p_en; enable_n [*4] |=> !bridge_en; endproperty
  a_en: assert property (p_en) else $error("drive on while disabled");
  property p_decay; $changed(fast_decay_select) |=> fast_decay == $past(fast_decay_select); endproperty
  a_decay: assert property (p_decay) else $error("decay mode not followed");
  property p_boost; current_level == SDS_LVL_BOOST |-> $past(ramp_current_gate); endproperty
  a_boost: assert property (p_boost) else $error("boost with gate off");
  property p_rest; current_level == SDS_LVL_REST |-> !$past(rest_reduction_inhibit); endproperty
  a_rest: assert property (p_rest) else $error("rest level while inhibited");
  property p_chop_go; chop_trip && bridge_en && !chop_off && !any_flt |=> chop_off; endproperty
  a_chop_go: assert property (p_chop_go) else $error("off-time not started");
  property p_chop_len; $fell(chop_off) && bridge_en |-> run_len == off_len; endproperty
  a_chop_len: assert property (p_chop_len) else $error("off-time length wrong");
endmodule : sds_top_props

bind sds_top sds_top_props u_props (.mclk(mclk), .rstn(rstn), .enable_n(enable_n),
  .ramp_current_gate(ramp_current_gate), .rest_reduction_inhibit(rest_reduction_inhibit),
  .fast_decay_select(fast_decay_select), .off_time_bit0(off_time_bit0), .off_time_bit1(off_time_bit1),
  .off_time_bit2(off_time_bit2), .chop_trip(chop_trip), .flt_undervolt(flt_undervolt),
  .flt_overvolt(flt_overvolt), .flt_overtemp(flt_overtemp), .flt_overload(flt_overload),
  .phase_pos(phase_pos), .phase_neg(phase_neg), .bridge_en(bridge_en), .current_level(current_level),
  .fast_decay(fast_decay), .chop_off(chop_off), .fault_n(fault_n), .fault_led(fault_led));
`default_nettype wire

// >>> sds_host_model.sv
// host motion controller model: step clock, direction, enable, ramp request
`timescale 1ns/1ps
`default_nettype none
module sds_host_model (
  input  wire logic mclk,
  output var  logic step_clk,
  output var  logic dir_in,
  output var  logic enable_n,
  output var  logic ramp_req
);
  logic act_edge;
  // idle values, drive released
  initial begin
    act_edge = 1'b1;
    {step_clk, dir_in, ramp_req} = 3'h0;
    enable_n = 1'b1;
  end
  // park the step line on its inactive level
  task automatic setup(input logic pol, input logic dir);
    @(posedge mclk);
    act_edge <= pol;
    step_clk <= ~pol;
    dir_in   <= dir;
  endtask : setup
  // enable is active low
  task automatic set_en(input logic v);
    @(posedge mclk);
    enable_n <= v;
  endtask : set_en
  // ramp request during acceleration
  task automatic set_ramp(input logic v);
    @(posedge mclk);
    ramp_req <= v;
  endtask : set_ramp
  // only the step clock is sent, each level held 3 cycles
  task automatic steps(input int n);
    repeat (n) begin
      @(posedge mclk);
      step_clk <= act_edge;
      repeat (3) @(posedge mclk);
      step_clk <= ~act_edge;
      repeat (2) @(posedge mclk);
    end
  endtask : steps
endmodule : sds_host_model
`default_nettype wire

// >>> sds_top_tb_top.sv
// self-checking bench for the stepper drive sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sds_params.svh"
module sds_top_tb_top
  import sds_pkg::*;
();
  typedef struct packed {
    logic [4:0] sel;  // edge pol, dir in, dir pol, half, five
    logic [7:0] n;
    logic [4:0] pos;
  } sds_tb_row_t;
  sds_tb_row_t rows [6] = '{'{5'h18, 8'h03, 5'h07}, '{5'h0E, 8'h03, 5'h05}, '{5'h15, 8'h0B, 5'h03},
                            '{5'h03, 8'h15, 5'h13}, '{5'h1B, 8'h01, 5'h01}, '{5'h00, 8'h02, 5'h05}};
  logic        mclk = 1'b0;
  logic        rstn, edge_pol, dir_pol, half, five, inhibit, gate, fast_sel, chop_trip, reg_wr, reg_rd, o0, o1, o2;
  logic [2:0]  off_code;
  logic [3:0]  flt;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic        step_clk, dir_in, enable_n, ramp_req;
  logic [4:0]  phase_pos, phase_neg;
  logic [1:0]  current_level;
  logic        bridge_en, fast_decay, chop_off, fault_n, fault_led, irq;
  int          err_total = 0;
  int          check_count = 0;
  int          n;

  always #12.5 mclk = ~mclk;
  assign {o2, o1, o0} = off_code;

  sds_top #(.REST_IDLE_CYCLES(20)) dut (.mclk(mclk), .rstn(rstn), .step_clk(step_clk), .dir_in(dir_in),
    .enable_n(enable_n), .ramp_req(ramp_req), .edge_polarity_select(edge_pol), .dir_polarity_select(dir_pol),
    .half_step_select(half), .rest_reduction_inhibit(inhibit), .five_phase_select(five),
    .ramp_current_gate(gate), .fast_decay_select(fast_sel), .off_time_bit0(o0),
    .off_time_bit1(o1), .off_time_bit2(o2), .chop_trip(chop_trip),
    .flt_undervolt(flt[0]), .flt_overvolt(flt[1]), .flt_overtemp(flt[2]), .flt_overload(flt[3]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .phase_pos(phase_pos), .phase_neg(phase_neg), .bridge_en(bridge_en), .current_level(current_level),
    .fast_decay(fast_decay), .chop_off(chop_off), .fault_n(fault_n), .fault_led(fault_led), .irq(irq));
  sds_host_model host (.mclk(mclk), .step_clk(step_clk), .dir_in(dir_in), .enable_n(enable_n),
    .ramp_req(ramp_req));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // windings driven at a sequence index, {neg, pos}
  function automatic logic [9:0] exp_phase(input logic fv, input int p);
    logic [9:0] r;
    int         t;
    r = 10'h000;
    for (int k = 0; k < 5; k++) begin
      t = fv ? (p + 20 - 4 * k) % 20 : ((k == 0 || k == 2) ? (p + 8 - k) % 8 : 0);
      r[k] = fv ? (t >= 1 && t <= 9) : (t >= 1 && t <= 3);
      r[5 + k] = fv ? (t >= 11) : (t >= 5);
    end
    return r;
  endfunction : exp_phase
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic settle(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : settle
  // bounded wait for the bridges to come on
  task automatic wait_bridge();
    n = 0;
    while (bridge_en !== 1'b1 && n < 20) begin
      settle(1);
      n++;
    end
    if (n == 20) begin
      err_total++;
      results();
    end
  endtask : wait_bridge
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a);
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : reg_read
  task automatic do_reset();
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
  endtask : do_reset

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rstn, edge_pol, dir_pol, half, five, inhibit, gate, fast_sel, chop_trip, reg_wr, reg_rd} = 11'h000;
    {off_code, flt, reg_addr, reg_wdata} = 47'h0;
    // step modes, phase counts, edges and directions
    foreach (rows[i]) begin
      host.setup(rows[i].sel[4], rows[i].sel[3]);
      host.set_en(1'b0);
      @(posedge mclk);
      {edge_pol, dir_pol, half, five} <= {rows[i].sel[4], rows[i].sel[2:0]};
      do_reset();
      wait_bridge();
      host.steps(rows[i].n);
      reg_read(`SDS_ADDR_STATE);
      chk(rd[4:0], rows[i].pos);
      chk({phase_neg, phase_pos}, exp_phase(rows[i].sel[0], rows[i].pos));
      chk(current_level, SDS_LVL_SLEW);
      settle(30);
      chk(current_level, SDS_LVL_REST);
      $display("row %0d done", i);
    end
    // rest inhibit and ramp current
    @(posedge mclk);
    {inhibit, gate} <= 2'h3;
    settle(2);
    chk(current_level, SDS_LVL_SLEW);
    host.set_ramp(1'b1);
    settle(4);
    chk(current_level, SDS_LVL_BOOST);
    @(posedge mclk);
    {inhibit, gate} <= 2'h0;
    settle(2);
    chk({bridge_en, current_level}, {1'b1, SDS_LVL_ZERO});
    host.set_ramp(1'b0);
    settle(4);
    chk(current_level, SDS_LVL_REST);
    $display("current levels done");
    // steps refused while disabled
    host.set_en(1'b1);
    settle(5);
    chk(bridge_en, 1'b0);
    host.steps(2);
    reg_read(`SDS_ADDR_STATE);
    chk(rd[4:0], 5'h05);
    host.set_en(1'b0);
    wait_bridge();
    $display("enable done");
    // each fault source, interrupt masked on even passes
    for (int i = 0; i < 4; i++) begin
      reg_write(`SDS_ADDR_MASK, i % 2);
      @(posedge mclk);
      flt <= 4'h1 << i;
      settle(2);
      chk({fault_n, bridge_en, fault_led}, {2'h0, i != 2});
      chk(irq, i % 2);
      reg_read(`SDS_ADDR_STATUS);
      chk(rd[0], 1'b1);
      @(posedge mclk);
      flt <= 4'h0;
      settle(2);
      chk(fault_n, 1'b1);
      reg_write(`SDS_ADDR_STATUS, 32'h0000000F);
      settle(1);
      chk(irq, 1'b0);
      wait_bridge();
    end
    reg_read(8'h10);
    chk(rd, 32'h00000000);
    $display("faults done");
    // every off-time code and both decay modes
    for (int c = 0; c < 8; c++) begin
      @(posedge mclk);
      {off_code, fast_sel, chop_trip} <= {c[2:0], c[0], 1'b1};
      @(posedge mclk);
      chop_trip <= 1'b0;
      settle(1);
      chk(fast_decay, c[0]);
      n = 0;
      while (chop_off === 1'b1 && n < 600) begin
        settle(1);
        n++;
      end
      chk(n + 1, 504 - 64 * c);
    end
    $display("chopper done");
    results();
  end
endmodule : sds_top_tb_top
`default_nettype wire
